// file: include/asrc_pkg.sv
`default_nettype none
package asrc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 100;
  // pin timing of the memory, in ns
  localparam int ADDRESS_ACCESS_TIME_NS = 50;
  localparam int SELECT_ACCESS_TIME_NS = 50;
  localparam int DESELECT_FLOAT_TIME_NS = 20;
  localparam int READ_CYCLE_MINIMUM_NS = 50;
  localparam int WRITE_START_FLOAT_TIME_NS = 15;
  localparam int OUTPUT_DISABLE_FLOAT_TIME_NS = 15;
  localparam int WRITE_PULSE_MINIMUM_NS = 45;
  localparam int SELECT_TO_WRITE_END_NS = 45;
  localparam int DATA_SETUP_NS = 35;
  localparam int WRITE_GAP_MINIMUM_NS = 5;
  localparam int WRITE_CYCLE_MINIMUM_NS = 50;
  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc
  localparam int ACCESS_CYC = ns_to_cyc(ADDRESS_ACCESS_TIME_NS);
  localparam int FLOAT_CYC = ns_to_cyc(WRITE_START_FLOAT_TIME_NS);
  localparam int WPULSE_CYC = ns_to_cyc(WRITE_PULSE_MINIMUM_NS);
  localparam int WGAP_CYC = ns_to_cyc(WRITE_GAP_MINIMUM_NS);
  localparam int RELEASE_CYC = ns_to_cyc(DESELECT_FLOAT_TIME_NS);
  localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage : asrc_pkg
`default_nettype wire

// file: hdl/asrc_host.sv
`timescale 1ns/100ps
`default_nettype none
module asrc_host #(
  parameter int ADDR_W = asrc_pkg::ADDR_W,
  parameter int DATA_W = asrc_pkg::DATA_W
) (
  input wire logic CLK_SYS_I, // 10 MHz system clock
  input wire logic RSTN_I, // async reset, active low
  input wire logic CE_I, // clock enable, freezes state when low
  input wire logic REQ_VALID_I, // request present
  output logic REQ_READY_O, // request taken when valid and ready
  input wire logic REQ_WRITE_I, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] REQ_ADDR_I, // byte address
  input wire logic [DATA_W-1:0] REQ_WDATA_I, // write byte
  output logic RD_VALID_O, // one-cycle pulse, read data ready
  output logic [DATA_W-1:0] RD_DATA_O, // read byte
  output logic [ADDR_W-1:0] MEM_ADDR_O, // memory address pins
  output logic MEM_SELECT_LOW_O, // select, active low
  output logic MEM_WRITE_STROBE_LOW_O, // write strobe, active low
  output logic MEM_OUTPUT_DRIVE_ENABLE_LOW_O, // output enable, active low
  output logic [DATA_W-1:0] MEM_DQ_O, // data toward memory
  output logic MEM_DQ_OE_O, // high while host drives data
  input wire logic [DATA_W-1:0] MEM_DQ_I // data from memory
);
  typedef enum logic [2:0] {ST_IDLE, ST_RD_ACC, ST_RD_END, ST_WR_FLOAT, ST_WR_PULSE,
    ST_WR_GAP} asrc_state_t;
  asrc_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic take;
  logic rd_sample;

  // every phase ends on the edge at which its down-counter shows one
  function automatic logic last_cycle(input logic [3:0] cnt);
    return (cnt == 4'h1);
  endfunction : last_cycle

  assign REQ_READY_O = (state_reg == ST_IDLE);
  assign take = CE_I && REQ_VALID_I && REQ_READY_O;
  // the read is sampled on the edge that closes the select-low cycle
  assign rd_sample = (state_reg == ST_RD_ACC) && last_cycle(cnt_reg);

  // one request in flight; each phase counts its least time before moving on
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= ST_IDLE;
      cnt_reg <= asrc_pkg::CNT_ZERO;
    end else if (CE_I) begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            // address is set with select in the same edge: host is slow enough
            state_reg <= REQ_WRITE_I ? ST_WR_FLOAT : ST_RD_ACC;
            cnt_reg <= REQ_WRITE_I ? 4'(asrc_pkg::FLOAT_CYC) : 4'(asrc_pkg::ACCESS_CYC);
          end
        end
        ST_RD_ACC: begin
          if (last_cycle(cnt_reg)) begin
            state_reg <= ST_RD_END;
            cnt_reg <= 4'(asrc_pkg::RELEASE_CYC);
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_RD_END: begin
          // wait for the device to float before a write may drive the bus
          if (last_cycle(cnt_reg)) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_WR_FLOAT: begin
          if (last_cycle(cnt_reg)) begin
            state_reg <= ST_WR_PULSE;
            cnt_reg <= 4'(asrc_pkg::WPULSE_CYC);
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_WR_PULSE: begin
          if (last_cycle(cnt_reg)) begin
            state_reg <= ST_WR_GAP;
            cnt_reg <= 4'(asrc_pkg::WGAP_CYC);
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_WR_GAP: begin
          if (last_cycle(cnt_reg)) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cnt_reg <= asrc_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // address and data held from take until idle again
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (take) begin
      addr_reg <= REQ_ADDR_I;
      wdata_reg <= REQ_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RD_VALID_O <= 1'b0;
      RD_DATA_O <= '0;
    end else if (CE_I) begin
      // a full period after address and select, so both access limits are met
      RD_VALID_O <= rd_sample;
      if (rd_sample) begin
        RD_DATA_O <= MEM_DQ_I;
      end
    end
  end

  // pins; select rises in the gap so every write is bounded by select and strobe
  assign MEM_ADDR_O = addr_reg;
  assign MEM_SELECT_LOW_O = !((state_reg == ST_RD_ACC) || (state_reg == ST_WR_FLOAT)
    || (state_reg == ST_WR_PULSE));
  assign MEM_WRITE_STROBE_LOW_O = !((state_reg == ST_WR_FLOAT)
    || (state_reg == ST_WR_PULSE));
  assign MEM_OUTPUT_DRIVE_ENABLE_LOW_O = !(state_reg == ST_RD_ACC);
  assign MEM_DQ_O = wdata_reg;
  assign MEM_DQ_OE_O = (state_reg == ST_WR_PULSE);

  // pin checks; the memory sees each level for a whole period after an edge
  a_write_pulse_len: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $rose(MEM_WRITE_STROBE_LOW_O)
    |-> (!$past(MEM_WRITE_STROBE_LOW_O, 2) && !$past(MEM_SELECT_LOW_O, 2)))
    else $error("write pulse too short");
  a_drive_in_strobe: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    MEM_DQ_OE_O
    |-> (!MEM_WRITE_STROBE_LOW_O && !$past(MEM_WRITE_STROBE_LOW_O)))
    else $error("data driven before strobe floated device");
  a_float_before_drive: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $rose(MEM_DQ_OE_O)
    |-> ($past(MEM_OUTPUT_DRIVE_ENABLE_LOW_O) && !$past(MEM_WRITE_STROBE_LOW_O)))
    else $error("data driven while memory outputs enabled");
  a_strobe_in_select: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !MEM_WRITE_STROBE_LOW_O
    |-> !MEM_SELECT_LOW_O)
    else $error("strobe low without select");
  a_addr_stable: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    (!MEM_SELECT_LOW_O && !$past(MEM_SELECT_LOW_O))
    |-> $stable(MEM_ADDR_O))
    else $error("address moved during access");
  a_addr_write_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $rose(MEM_WRITE_STROBE_LOW_O)
    |-> $stable(MEM_ADDR_O))
    else $error("address moved at write end");
  a_gap_select_high: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    (state_reg == ST_WR_GAP)
    |-> (MEM_SELECT_LOW_O && MEM_WRITE_STROBE_LOW_O && !MEM_DQ_OE_O))
    else $error("no deselect between writes");
  a_oe_no_write: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !MEM_OUTPUT_DRIVE_ENABLE_LOW_O
    |-> (MEM_WRITE_STROBE_LOW_O && !MEM_DQ_OE_O))
    else $error("output enable during write");
  a_read_pulse: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $rose(RD_VALID_O)
    |-> (!$past(MEM_OUTPUT_DRIVE_ENABLE_LOW_O) && !$past(MEM_SELECT_LOW_O)))
    else $error("read data sampled without select and output enable");
  a_read_one_cycle: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    (RD_VALID_O && CE_I)
    |=> !RD_VALID_O)
    else $error("read valid longer than one cycle");
  a_data_setup: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    ($rose(MEM_WRITE_STROBE_LOW_O) && CE_I)
    |-> $past(MEM_DQ_OE_O))
    else $error("write ended without data setup");
  // a frozen access must hold its pins, or the memory would see a cut write
  a_freeze_pins: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !CE_I
    |=> ($stable(MEM_SELECT_LOW_O) && $stable(MEM_WRITE_STROBE_LOW_O)
      && $stable(MEM_ADDR_O)))
    else $error("pins moved while clock enable low");
  c_read: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    RD_VALID_O);
  c_write: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $fell(MEM_DQ_OE_O));
  c_b2b: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    (state_reg == ST_WR_GAP) ##3 MEM_DQ_OE_O);
  c_write_then_read: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $fell(MEM_DQ_OE_O) ##[1:4] RD_VALID_O);
  c_frozen_access: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !CE_I && !MEM_SELECT_LOW_O);
endmodule : asrc_host
`default_nettype wire

// file: testbench/asrc_sram_model.sv
`timescale 1ns/100ps
`default_nettype none
module asrc_sram_model (
  input wire logic [14:0] addr_i, // address
  input wire logic select_low_i, // active low
  input wire logic write_strobe_low_i, // active low
  input wire logic output_drive_enable_low_i, // active low
  input wire logic [7:0] dq_i, // resolved bus
  output logic [7:0] dq_o, // array output
  output logic drive_o // array drives bus
);
  logic [7:0] mem [0:32767], last_q = 8'h00, wr_data;
  logic [14:0] wr_addr;
  wire wr_on = !select_low_i && !write_strobe_low_i;
  assign drive_o = !select_low_i && write_strobe_low_i && !output_drive_enable_low_i;
  always @(*) if (wr_on) {wr_addr, wr_data} = {addr_i, dq_i}; // open until the write ends
  always @(negedge wr_on) mem[wr_addr] = wr_data;
  always @(*) if (drive_o) last_q = mem[addr_i];
  // floating bus reads back inverted, so stale data never passes
  assign #15 dq_o = drive_o ? mem[addr_i] : ~last_q;
endmodule : asrc_sram_model
`default_nettype wire

// file: testbench/tb_asrc_host.sv
`timescale 1ns/100ps
`default_nettype none
module tb_asrc_host;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, valid = 1'b0, wr = 1'b0;
  logic [14:0] addr = 15'h0000;
  logic [7:0] wdata = 8'h00;
  wire ready, rd_valid, sel_low, we_low, oe_low, dq_oe, drv;
  wire [7:0] rd_data, dq_host, dq_mem, dq_bus;
  wire [14:0] mem_addr;
  int n_fail = 0, tests_run = 0;
  always #50 clk = ~clk;
  assign #1 dq_bus = dq_oe ? dq_host : dq_mem; // lag: a zero-hold release misses the write end
  asrc_host i_asrc_host (.CLK_SYS_I(clk), .RSTN_I(rstn), .CE_I(ce), .REQ_VALID_I(valid),
    .REQ_READY_O(ready), .REQ_WRITE_I(wr), .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata),
    .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data), .MEM_ADDR_O(mem_addr), .MEM_DQ_O(dq_host),
    .MEM_SELECT_LOW_O(sel_low), .MEM_WRITE_STROBE_LOW_O(we_low), .MEM_DQ_OE_O(dq_oe),
    .MEM_OUTPUT_DRIVE_ENABLE_LOW_O(oe_low), .MEM_DQ_I(dq_bus));
  asrc_sram_model i_asrc_sram_model (.addr_i(mem_addr), .select_low_i(sel_low),
    .write_strobe_low_i(we_low), .output_drive_enable_low_i(oe_low), .dq_i(dq_bus),
    .dq_o(dq_mem), .drive_o(drv));
  always @(negedge clk) if (rstn) check({15'h0000, dq_oe & drv}, 16'h0000);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) n_fail++;
    if (seen !== exp) $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
  endtask : check
  task automatic issue(input logic w, input logic [14:0] a, input logic [7:0] d);
    valid = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    for (int n = 0; n < 20 && ready !== 1'b1; n++) @(posedge clk) #1;
    check({15'h0000, ready}, 16'h0001);
    @(posedge clk) #1;
    valid = 1'b0;
    @(posedge clk) #1;
  endtask : issue
  task automatic read_back(input logic [14:0] a, input logic [7:0] exp);
    issue(1'b0, a, 8'h00);
    check({7'h00, rd_valid, rd_data}, {8'h01, exp});
    @(posedge clk) #1;
    check({15'h0000, rd_valid}, 16'h0000);
    check({11'h000, sel_low, we_low, oe_low, dq_oe, rd_valid}, 16'h001C);
  endtask : read_back
  task automatic t_freeze_read();
    valid = 1'b1;
    wr = 1'b0;
    addr = 15'h7FFF;
    @(posedge clk) #1;
    valid = 1'b0;
    ce = 1'b0;
    repeat (3) @(posedge clk) #1;
    check({13'h0000, sel_low, oe_low, rd_valid}, 16'h0000);
    ce = 1'b1;
    @(posedge clk) #1;
    check({7'h00, rd_valid, rd_data}, {8'h01, 8'hA5});
    @(posedge clk) #1;
    check({15'h0000, ready}, 16'h0001);
    $display("read frozen mid-access: done");
  endtask : t_freeze_read
  task automatic t_table();
    logic [14:0] a [5] = '{15'h0000, 15'h7FFF, 15'h4000, 15'h2AAA, 15'h0000};
    logic [7:0] d [5] = '{8'h5A, 8'hA5, 8'h3C, 8'hFF, 8'hC3};
    for (int i = 0; i < 5; i++) issue(1'b1, a[i], d[i]);
    for (int i = 1; i < 5; i++) read_back(a[i], d[i]);
    $display("back-to-back writes then reads: done");
  endtask : t_table
  task automatic t_freeze();
    ce = 1'b0;
    valid = 1'b1;
    repeat (3) @(posedge clk) #1;
    check({14'h0000, sel_low, rd_valid}, 16'h0002);
    ce = 1'b1;
    read_back(15'h0000, 8'hC3);
    $display("frozen request: done");
  endtask : t_freeze
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge clk) #1;
    rstn = 1'b1;
    t_table();
    t_freeze();
    t_freeze_read();
    give_verdict();
  end
  initial begin
    #100000 n_fail++;
    give_verdict();
  end
endmodule : tb_asrc_host
`default_nettype wire
